// ### common/eqlpc_pkg.sv
// constants and types shared by the equalizer lock and polarity control block
//
// Contract
// - In hold mode the settled equalization stays frozen until power-down or a pin restart.
// - In hold mode the settled indicator stays high through signal loss until a pin restart.
// - In free mode settled rises only after the setting is unchanged for 100 lines.
// - With hold-select low the block adapts freely and never freezes the setting.
// - In free mode a changed solution drops settled and adaptation starts over.
// - The polarity pin reports swapped inputs high and nominal polarity low.
// - The video path is inverted exactly when the polarity pin level is high.
// - An external driver on the polarity pin overrides the detector and decides inversion.
// - The chroma pin shows burst presence and the path relies on burst only when it is high.
// - An external driver on the chroma pin overrides the colour detector.
package eqlpc_pkg;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int CLK_MHZ      = 250;
  localparam int T_TOGGLE_MS  = 1;
  localparam int TOGGLE_CYC   = T_TOGGLE_MS * 1000 * CLK_MHZ;
  localparam int TOG_W        = 18;
  localparam int SETTLE_LINES = 100;
  localparam int LINE_W       = 7;

  // ***************************************************************
  // widths and reset values
  // ***************************************************************
  localparam int         EQ_W     = 6;
  localparam logic [5:0] EQ_RESET = 6'h00;

  // ***************************************************************
  // register map
  // ***************************************************************
  localparam int         ADR_W       = 8;
  localparam logic [7:0] ADR_CTRL    = 8'h00;
  localparam logic [7:0] ADR_STATUS  = 8'h04;
  localparam logic [7:0] ADR_EQ      = 8'h08;
  localparam logic [7:0] ADR_IRQ_ST  = 8'h0C;
  localparam logic [7:0] ADR_IRQ_MSK = 8'h10;
  localparam logic [1:0] CTRL_RESET  = 2'h3;
  localparam int         CTRL_POL_EN = 0;
  localparam int         CTRL_CHR_EN = 1;
  localparam int         ST_SETTLED  = 0;
  localparam int         ST_HELD     = 1;
  localparam int         ST_INVERT   = 2;
  localparam int         ST_CHROMA   = 3;
  localparam int         ST_HOLDSEL  = 4;
  localparam int         IRQ_N       = 3;
  localparam int         IRQ_RISE    = 0;
  localparam int         IRQ_FALL    = 1;
  localparam int         IRQ_RESTART = 2;

  // adaptation states
  typedef enum logic [1:0] {
    ACQ     = 2'b00,
    SETTLED = 2'b01,
    HELD    = 2'b10
  } eqlpc_mode_t;

endpackage

// ### rtl/eqlpc_top.sv
// settle, hold, pin restart and pin overdrive control with a wishbone register slave
//
// Our own choices: the Wishbone slave port and the placing of the registers.
module eqlpc_top #(
  parameter int TOGGLE_MIN = eqlpc_pkg::TOGGLE_CYC
) (
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire logic                       ce,
  // wishbone slave
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [eqlpc_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  output logic                            irq,
  // adaptation engine, same clock
  input  wire logic                       line_stb,
  input  wire logic                       sig_present,
  input  wire logic [eqlpc_pkg::EQ_W-1:0] eq_proposal,
  input  wire logic                       det_swapped,
  input  wire logic                       det_burst,
  output logic      [eqlpc_pkg::EQ_W-1:0] eq_setting,
  output logic                            acq_restart,
  output logic                            invert_path,
  output logic                            burst_valid,
  // pins
  input  wire logic                       hold_sel_pin,
  output logic                            settled_indicator,
  input  wire logic                       pol_pin_i,
  output logic                            pol_pin_o,
  output logic                            pol_pin_oe,
  input  wire logic                       chroma_pin_i,
  output logic                            chroma_pin_o,
  output logic                            chroma_pin_oe
);
  import eqlpc_pkg::*;

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic [1:0]        hold_s;
    logic [1:0]        pol_s;
    logic [1:0]        chr_s;
    eqlpc_mode_t       mode;
    logic [EQ_W-1:0]   eq;
    logic [LINE_W-1:0] lines;
    logic              tog_act;
    logic              tog_base;
    logic [TOG_W-1:0]  tog_cnt;
    logic              restart;
    logic              pol_drv;
    logic              chr_drv;
    logic [1:0]        ctrl;
    logic [IRQ_N-1:0]  irq_st;
    logic [IRQ_N-1:0]  irq_msk;
    logic              ack;
    logic [31:0]       rdat;
  } eqlpc_state_t;

  localparam logic [TOG_W-1:0]  TOG_LIM  = TOG_W'(TOGGLE_MIN);
  localparam logic [LINE_W-1:0] LINE_LIM = LINE_W'(SETTLE_LINES - 1);

  eqlpc_state_t s_r;
  eqlpc_state_t s_nxt;
  logic         restart_now;
  logic         code_chg;
  logic         settle_now;
  logic         bus_req;
  logic [31:0]  rd_mux;
  logic [IRQ_N-1:0] ev;

  // restart when the pin returns to its old level after a long enough excursion
  assign restart_now = ce && s_r.tog_act && (s_r.pol_s[1] == s_r.tog_base)
                       && (s_r.tog_cnt >= TOG_LIM);
  assign code_chg    = (eq_proposal != s_r.eq) || !sig_present;
  assign settle_now  = line_stb && !code_chg && (s_r.lines == LINE_LIM);
  assign bus_req     = wb_cyc_i && wb_stb_i && !s_r.ack;

  // ***************************************************************
  // register read mux
  // ***************************************************************
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (wb_adr_i == ADR_CTRL) begin
      rd_mux[1:0] = s_r.ctrl;
    end else if (wb_adr_i == ADR_STATUS) begin
      rd_mux[ST_SETTLED] = (s_r.mode != ACQ);
      rd_mux[ST_HELD]    = (s_r.mode == HELD);
      rd_mux[ST_INVERT]  = s_r.pol_s[1];
      rd_mux[ST_CHROMA]  = s_r.chr_s[1];
      rd_mux[ST_HOLDSEL] = s_r.hold_s[1];
    end else if (wb_adr_i == ADR_EQ) begin
      rd_mux[EQ_W-1:0] = s_r.eq;
    end else if (wb_adr_i == ADR_IRQ_ST) begin
      rd_mux[IRQ_N-1:0] = s_r.irq_st;
    end else if (wb_adr_i == ADR_IRQ_MSK) begin
      rd_mux[IRQ_N-1:0] = s_r.irq_msk;
    end
  end

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    s_nxt = s_r;
    ev    = '0;
    if (ce) begin
      // pin synchronisers, second stage is the only reader of the first
      s_nxt.hold_s  = {s_r.hold_s[0], hold_sel_pin};
      s_nxt.pol_s   = {s_r.pol_s[0], pol_pin_i};
      s_nxt.chr_s   = {s_r.chr_s[0], chroma_pin_i};
      // own detector levels driven out weakly, outside drivers win
      s_nxt.pol_drv = det_swapped;
      s_nxt.chr_drv = det_burst;
      s_nxt.restart = restart_now;

      // toggle watcher on the synchronised polarity level; the idle base
      // follows the second stage so the first stage has no other reader
      if (!s_r.tog_act) begin
        s_nxt.tog_base = s_r.pol_s[1];
        if (s_r.pol_s[1] != s_r.tog_base) begin
          s_nxt.tog_act  = 1'b1;
          s_nxt.tog_base = s_r.tog_base;
          s_nxt.tog_cnt  = '0;
        end
      end else if (s_r.pol_s[1] == s_r.tog_base) begin
        s_nxt.tog_act = 1'b0;
      end else if (s_r.tog_cnt < TOG_LIM) begin
        s_nxt.tog_cnt = s_r.tog_cnt + TOG_W'(1);
      end

      // adaptation state machine
      case (s_r.mode)
        ACQ: begin
          s_nxt.eq = eq_proposal;
          if (code_chg) begin
            s_nxt.lines = '0;
          end else if (settle_now) begin
            s_nxt.mode  = s_r.hold_s[1] ? HELD : SETTLED;
            s_nxt.lines = '0;
            ev[IRQ_RISE] = 1'b1;
          end else if (line_stb) begin
            s_nxt.lines = s_r.lines + LINE_W'(1);
          end
        end
        SETTLED: begin
          s_nxt.eq = eq_proposal;
          if (code_chg) begin
            s_nxt.mode   = ACQ;
            s_nxt.lines  = '0;
            ev[IRQ_FALL] = 1'b1;
          end else if (s_r.hold_s[1]) begin
            s_nxt.mode = HELD;
          end
        end
        HELD: begin
          // setting frozen, signal loss ignored
          if (!s_r.hold_s[1]) begin
            s_nxt.mode = SETTLED;
          end
        end
        default: begin
          s_nxt.mode = ACQ;
        end
      endcase

      // a completed toggle wins over everything else
      if (restart_now) begin
        if (s_r.mode != ACQ) begin
          ev[IRQ_FALL] = 1'b1;
        end
        ev[IRQ_RISE]    = 1'b0;
        ev[IRQ_RESTART] = 1'b1;
        s_nxt.mode      = ACQ;
        s_nxt.eq        = EQ_RESET;
        s_nxt.lines     = '0;
      end

      // wishbone slave, one wait state then ack for one cycle
      s_nxt.ack  = bus_req;
      s_nxt.rdat = bus_req ? rd_mux : 32'h0000_0000;
      if (bus_req && wb_we_i && wb_sel_i[0]) begin
        if (wb_adr_i == ADR_CTRL) begin
          s_nxt.ctrl = wb_dat_i[1:0];
        end else if (wb_adr_i == ADR_IRQ_MSK) begin
          s_nxt.irq_msk = wb_dat_i[IRQ_N-1:0];
        end
      end
      // sticky events, write one clears, a new event wins
      s_nxt.irq_st = s_r.irq_st;
      if (bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_IRQ_ST) begin
        s_nxt.irq_st = s_r.irq_st & ~wb_dat_i[IRQ_N-1:0];
      end
      s_nxt.irq_st = s_nxt.irq_st | ev;
    end
  end

  // ***************************************************************
  // state register
  // ***************************************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_r         <= '0;
      s_r.mode    <= ACQ;
      s_r.eq      <= EQ_RESET;
      s_r.ctrl    <= CTRL_RESET;
      s_r.rdat    <= 32'h0000_0000;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign wb_dat_o          = s_r.rdat;
  assign wb_ack_o          = s_r.ack;
  assign irq               = |(s_r.irq_st & s_r.irq_msk);
  assign eq_setting        = s_r.eq;
  assign acq_restart       = s_r.restart;
  assign settled_indicator = (s_r.mode != ACQ);
  assign invert_path       = s_r.pol_s[1];
  assign burst_valid       = s_r.chr_s[1];
  assign pol_pin_o         = s_r.pol_drv;
  assign pol_pin_oe        = s_r.ctrl[CTRL_POL_EN];
  assign chroma_pin_o      = s_r.chr_drv;
  assign chroma_pin_oe     = s_r.ctrl[CTRL_CHR_EN];

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  held_freeze_a: assert property (
    (s_r.mode == HELD && !restart_now) |=> $stable(eq_setting))
    else $error("held setting changed");

  held_keep_a: assert property (
    (s_r.mode == HELD && !restart_now) |=> settled_indicator)
    else $error("settled dropped while held");

  settle_lines_a: assert property (
    (ce && s_r.mode == ACQ && !restart_now && !settle_now) |=> !settled_indicator)
    else $error("settled rose before 100 lines");

  settle_rise_a: assert property (
    (ce && s_r.mode == ACQ && settle_now && !restart_now) |=> settled_indicator)
    else $error("settled missed after 100 lines");

  free_mode_a: assert property (
    (ce && !s_r.hold_s[1] && s_r.mode != HELD) |=> s_r.mode != HELD)
    else $error("froze with hold select low");

  solution_unlock_a: assert property (
    (ce && s_r.mode == SETTLED && code_chg) |=> !settled_indicator)
    else $error("no unlock on changed solution");

  pol_drive_a: assert property (
    (rst_b && ce) |=> pol_pin_o == $past(det_swapped))
    else $error("polarity pin not driven from detector");

  invert_pin_a: assert property (
    (rst_b && $past(rst_b) && ce && $past(ce)) |=> invert_path == $past(pol_pin_i, 2))
    else $error("inversion not following pin");

  chroma_pin_a: assert property (
    (rst_b && $past(rst_b) && ce && $past(ce)) |=> burst_valid == $past(chroma_pin_i, 2))
    else $error("burst use not following pin");

  pin_restart_a: assert property (
    restart_now |=> (!settled_indicator && eq_setting == EQ_RESET && acq_restart))
    else $error("restart not taken");

  wb_ack_a: assert property (
    (ce && wb_ack_o) |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  // bus, flags, clock enable and pin drive enables
  ack_answer_a: assert property (
    (rst_b && ce && wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not answered after one wait state");

  dat_idle_a: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");

  irq_clear_a: assert property (
    (ce && bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_IRQ_ST
     && wb_dat_i[IRQ_RESTART] && !restart_now) |=> !s_r.irq_st[IRQ_RESTART])
    else $error("restart flag not cleared by write one");

  restart_flag_a: assert property (
    restart_now |=> s_r.irq_st[IRQ_RESTART])
    else $error("restart flag lost");

  rise_flag_a: assert property (
    (rst_b && ce && s_r.mode == ACQ && settle_now && !restart_now) |=> s_r.irq_st[IRQ_RISE])
    else $error("settle flag not set");

  ce_freeze_a: assert property (
    (rst_b && !ce) |=> $stable(s_r))
    else $error("state moved with enable low");

  drive_on_a: assert property (
    (rst_b && ce && bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_CTRL
     && wb_dat_i[CTRL_POL_EN]) |=> pol_pin_oe)
    else $error("polarity drive not switched on");

  drive_off_a: assert property (
    (rst_b && ce && bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_CTRL
     && !wb_dat_i[CTRL_CHR_EN]) |=> !chroma_pin_oe)
    else $error("chroma drive not switched off");

  // adaptation
  short_toggle_a: assert property (
    (ce && s_r.tog_act && s_r.pol_s[1] == s_r.tog_base && s_r.tog_cnt < TOG_LIM)
    |=> !acq_restart)
    else $error("restart from a short toggle");

  settle_hold_a: assert property (
    (rst_b && ce && s_r.mode == ACQ && settle_now && s_r.hold_s[1] && !restart_now)
    |=> s_r.mode == HELD)
    else $error("hold not entered on settling");

  held_entry_a: assert property (
    (rst_b && ce && s_r.mode == SETTLED && s_r.hold_s[1] && !code_chg && !restart_now)
    |=> s_r.mode == HELD)
    else $error("hold not entered while settled");

  held_exit_a: assert property (
    (rst_b && ce && s_r.mode == HELD && !s_r.hold_s[1] && !restart_now)
    |=> s_r.mode == SETTLED)
    else $error("hold kept with hold select low");

  free_follow_a: assert property (
    (rst_b && ce && s_r.mode != HELD && !restart_now) |=> eq_setting == $past(eq_proposal))
    else $error("setting not following in free mode");

  // pins
  chroma_drive_a: assert property (
    (rst_b && ce) |=> chroma_pin_o == $past(det_burst))
    else $error("chroma pin not driven from detector");

  held_c:    cover property (s_r.mode == SETTLED ##1 s_r.mode == HELD);
  unlock_c:  cover property (s_r.mode == SETTLED ##1 s_r.mode == ACQ);
  restart_c: cover property (s_r.mode == HELD ##1 restart_now);
  short_c:   cover property (s_r.tog_act && s_r.pol_s[1] == s_r.tog_base && s_r.tog_cnt < TOG_LIM);
  loss_c:    cover property (s_r.mode == HELD && !sig_present);

endmodule

// ### dv/eqlpc_board.sv
// board strapping and pin drivers around the equalizer control block
// resolves the shared pins; an outside driver always beats the weak device drive
module eqlpc_board_pins (
  input  wire logic hold_tie,
  input  wire logic settled_indicator,
  output logic      hold_sel_pin,
  input  wire logic pol_pin_o,
  input  wire logic pol_pin_oe,
  input  wire logic pol_ext_en,
  input  wire logic pol_ext_val,
  output logic      pol_pin,
  input  wire logic chroma_pin_o,
  input  wire logic chroma_pin_oe,
  input  wire logic chroma_ext_en,
  input  wire logic chroma_ext_val,
  output logic      chroma_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ***************************************************************
  // strapping and pin resolution
  // ***************************************************************
  // hold mode by tying settled to hold select, grounded otherwise
  assign hold_sel_pin = hold_tie & settled_indicator;
  // outside driver wins; undriven pins sit on a board pull-down
  assign pol_pin    = pol_ext_en ? pol_ext_val : (pol_pin_oe & pol_pin_o);
  assign chroma_pin = chroma_ext_en ? chroma_ext_val : (chroma_pin_oe & chroma_pin_o);
endmodule

// ### dv/eqlpc_tb.sv
// self-checking bench for the equalizer lock and polarity control block
module eqlpc_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import eqlpc_pkg::*;
  localparam int TMIN = 20;
  logic clk, rst_b, ce, cyc, stb, we, line_stb, sig_present, det_swapped, det_burst;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_i, dat_o, q;
  logic ack, irq, acq_restart, invert_path, burst_valid, settled, hold_sel, hold_tie;
  logic [5:0] eq_proposal, eq_setting;
  logic pol_pin, pol_o, pol_oe, pol_en, pol_val;
  logic chr_pin, chr_o, chr_oe, chr_en, chr_val;
  int err_count = 0;
  int checks = 0;
  int n;
  // ***************************************************************
  // clock, design and board
  // ***************************************************************
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  eqlpc_top #(.TOGGLE_MIN(TMIN)) eqlpc_top_inst (.clk(clk), .rst_b(rst_b), .ce(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq(irq), .line_stb(line_stb),
    .sig_present(sig_present), .eq_proposal(eq_proposal), .det_swapped(det_swapped),
    .det_burst(det_burst), .eq_setting(eq_setting), .acq_restart(acq_restart),
    .invert_path(invert_path), .burst_valid(burst_valid), .hold_sel_pin(hold_sel),
    .settled_indicator(settled), .pol_pin_i(pol_pin), .pol_pin_o(pol_o),
    .pol_pin_oe(pol_oe), .chroma_pin_i(chr_pin), .chroma_pin_o(chr_o),
    .chroma_pin_oe(chr_oe));
  eqlpc_board_pins eqlpc_board_pins_inst (.hold_tie(hold_tie), .settled_indicator(settled),
    .hold_sel_pin(hold_sel), .pol_pin_o(pol_o), .pol_pin_oe(pol_oe), .pol_ext_en(pol_en),
    .pol_ext_val(pol_val), .pol_pin(pol_pin), .chroma_pin_o(chr_o), .chroma_pin_oe(chr_oe),
    .chroma_ext_en(chr_en), .chroma_ext_val(chr_val), .chroma_pin(chr_pin));
  // ***************************************************************
  // tasks
  // ***************************************************************
  // classic wishbone single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    dat_i <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk("register read", exp, q);
  endtask
  // one strobe per video line, each followed by an idle cycle
  task automatic lines(input int cnt);
    repeat (cnt) begin
      @(posedge clk) line_stb <= 1'b1;
      @(posedge clk) line_stb <= 1'b0;
    end
    repeat (2) @(posedge clk);
  endtask
  // drive the polarity pin to the opposite level for a number of cycles
  task automatic pol_pulse(input int cyc_n);
    @(posedge clk);
    pol_val <= ~pol_pin;
    pol_en <= 1'b1;
    repeat (cyc_n) @(posedge clk);
    pol_en <= 1'b0;
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ***************************************************************
  // tests
  // ***************************************************************
  initial begin
    #200us;
    err_count++;
    final_report();
  end
  initial begin
    {rst_b, cyc, stb, we, line_stb, det_swapped, det_burst, hold_tie} = '0;
    {pol_en, pol_val, chr_en, chr_val} = '0;
    adr = '0;
    sel = '0;
    ce = 1'b1;
    dat_i = '0;
    sig_present = 1'b1;
    eq_proposal = 6'h05;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    // reset values and an unmapped place
    rd(ADR_CTRL, 32'h3);
    rd(ADR_IRQ_MSK, 32'h0);
    rd(8'h20, 32'h0);
    // free mode: settled only after the hundredth unchanged line
    lines(99);
    chk("settled early", 0, settled);
    lines(1);
    chk("settled", 1, settled);
    wb(1'b1, ADR_IRQ_MSK, 32'h1);
    chk("irq raised", 1, irq);
    wb(1'b1, ADR_IRQ_ST, 32'h7);
    chk("irq cleared", 0, irq);
    @(posedge clk) eq_proposal <= 6'h0A;
    lines(1);
    chk("settled dropped", 0, settled);
    chk("eq follows", 32'hA, eq_setting);
    // hold mode: freeze through proposal change and signal loss
    hold_tie <= 1'b1;
    lines(100);
    repeat (6) @(posedge clk);
    rd(ADR_STATUS, 32'h13);
    @(posedge clk) eq_proposal <= 6'h21;
    sig_present <= 1'b0;
    lines(3);
    chk("eq frozen", 32'hA, eq_setting);
    chk("settled kept", 1, settled);
    pol_pulse(TMIN / 4);
    repeat (8) @(posedge clk);
    chk("short toggle", 1, settled);
    // full toggle restarts acquisition
    pol_pulse(TMIN + 10);
    n = 0;
    while (acq_restart !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk("restart pulse", 1, acq_restart);
    @(posedge clk);
    chk("settled cleared", 0, settled);
    hold_tie <= 1'b0;
    sig_present <= 1'b1;
    rd(ADR_IRQ_ST, 32'h7);
    // clock enable low freezes the applied setting
    ce <= 1'b0;
    eq_proposal <= 6'h15;
    repeat (4) @(posedge clk);
    chk("eq frozen by enable", 32'h21, eq_setting);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    chk("eq after enable", 32'h15, eq_setting);
    // polarity and chroma reporting and override
    det_swapped <= 1'b1;
    det_burst <= 1'b1;
    repeat (6) @(posedge clk);
    chk("pol pin", 1, pol_pin);
    chk("invert", 1, invert_path);
    chk("burst", 1, burst_valid);
    pol_val <= 1'b0;
    pol_en <= 1'b1;
    chr_val <= 1'b0;
    chr_en <= 1'b1;
    repeat (6) @(posedge clk);
    chk("invert forced", 0, invert_path);
    chk("burst forced", 0, burst_valid);
    {pol_en, chr_en} <= 2'b00;
    wb(1'b1, ADR_CTRL, 32'h0);
    chk("drive off", 0, {pol_oe, chr_oe});
    final_report();
  end
endmodule
